//--- agc_pkg.sv
// Behaviour
// - Keep a 16-bit voltage gain coefficient and scale each voltage result.
// - Keep a separate 16-bit temperature gain coefficient and scale temperature results.
// - At power-on each coefficient loads a factory trimmed value, not a constant.
// - A voltage gain calibration replaces the voltage coefficient with the measured value.
// - A temperature gain calibration replaces the temperature coefficient with measured value.
// - Software writes to a coefficient are accepted only once the converter has been enabled and idle for AGC_IDLE_MIN_NS.
package agc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] AGC_VOLT_GAIN_ADDR = 32'hffff0540;
  localparam logic [31:0] AGC_TEMP_GAIN_ADDR = 32'hffff0544;
  localparam logic [31:0] AGC_STATUS_ADDR    = 32'hffff05f0;
  localparam logic [31:0] AGC_VOLT_RES_ADDR  = 32'hffff05f4;
  localparam logic [31:0] AGC_TEMP_RES_ADDR  = 32'hffff05f8;

  // Status register fields
  localparam int AGC_STAT_ENABLED  = 0;
  localparam int AGC_STAT_IDLE     = 1;
  localparam int AGC_STAT_SETTLED  = 2;
  localparam int AGC_STAT_REJECTED = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int AGC_CLK_HZ        = 20000000;
  localparam int AGC_IDLE_MIN_NS   = 23000;
  localparam int AGC_CLK_PERIOD_NS = 1000000000 / AGC_CLK_HZ;
  // Least time: round up to whole cycles
  localparam int AGC_IDLE_CYCLES   =
    (AGC_IDLE_MIN_NS + AGC_CLK_PERIOD_NS - 1) / AGC_CLK_PERIOD_NS;
  localparam int AGC_IDLE_CNT_W    = 10;

  // AHB-Lite encodings
  localparam logic [1:0] AGC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] AGC_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] AGC_HSIZE_WORD    = 3'h2;
  localparam logic       AGC_HRESP_OKAY    = 1'h0;

  // Fixed point: gain 0x8000 means unity
  localparam int AGC_GAIN_FRAC = 15;

endpackage

//--- agc_scaler.sv
`timescale 1ns/10ps
// Scales one conversion result by a gain coefficient, registered output
module agc_scaler
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rst_sync_b,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample,
  input  wire logic [DATA_W-1:0] gain,
  output logic      [DATA_W-1:0] scaled_ff,
  output logic                   scaled_valid_ff
);

  logic [2*DATA_W-1:0] product;
  logic [2*DATA_W-1:0] shifted;
  logic [DATA_W-1:0]   nxt_scaled;
  logic                nxt_scaled_valid;

  // ----------------------------------------------------------------
  // Multiply and saturate
  // ----------------------------------------------------------------
  always_comb begin
    product          = sample * gain;
    shifted          = product >> AGC_GAIN_FRAC;
    nxt_scaled       = scaled_ff;
    nxt_scaled_valid = sample_valid;
    if (sample_valid) begin
      if (|shifted[2*DATA_W-1:DATA_W]) begin
        nxt_scaled = '1;  // Saturate on overflow
      end else begin
        nxt_scaled = shifted[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scaled_ff       <= '0;
      scaled_valid_ff <= 1'b0;
    end else begin
      scaled_ff       <= nxt_scaled;
      scaled_valid_ff <= nxt_scaled_valid;
    end
  end

endmodule

//--- agc_regs.sv
`timescale 1ns/10ps
// Gain calibration coefficient registers for the voltage and temperature channels
module agc_regs
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Factory trim, sampled after reset release
  input  wire logic [DATA_W-1:0] trim_volt_gain,
  input  wire logic [DATA_W-1:0] trim_temp_gain,
  // Converter state from the mode logic
  input  wire logic              converter_enabled,
  input  wire logic              converter_idle,
  // Self gain calibration results
  input  wire logic              volt_cal_done,
  input  wire logic              temp_cal_done,
  input  wire logic [DATA_W-1:0] cal_gain,
  // Raw conversions
  input  wire logic              volt_sample_valid,
  input  wire logic [DATA_W-1:0] volt_sample,
  input  wire logic              temp_sample_valid,
  input  wire logic [DATA_W-1:0] temp_sample,
  // Scaled conversions and coefficient view
  output logic      [DATA_W-1:0] volt_result,
  output logic                   volt_result_valid,
  output logic      [DATA_W-1:0] temp_result,
  output logic                   temp_result_valid,
  output logic      [DATA_W-1:0] volt_gain,
  output logic      [DATA_W-1:0] temp_gain
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]         volt_gain_ff;
  logic [DATA_W-1:0]         temp_gain_ff;
  logic                      trim_loaded_ff;
  logic [AGC_IDLE_CNT_W-1:0] idle_cnt_ff;
  logic                      settled_ff;
  logic                      rejected_ff;
  logic [DATA_W-1:0]         nxt_volt_gain;
  logic [DATA_W-1:0]         nxt_temp_gain;
  logic                      nxt_trim_loaded;
  logic [AGC_IDLE_CNT_W-1:0] nxt_idle_cnt;
  logic                      nxt_settled;
  logic                      nxt_rejected;

  // Bus pipeline
  logic        wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        nxt_wr_pend;
  logic [31:0] nxt_wr_addr;
  logic [31:0] nxt_hrdata;
  logic        addr_phase;

  localparam logic [AGC_IDLE_CNT_W-1:0] IDLE_TARGET =
    AGC_IDLE_CNT_W'(AGC_IDLE_CYCLES);

  // ----------------------------------------------------------------
  // Idle settling timer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_idle_cnt = idle_cnt_ff;
    nxt_settled  = settled_ff;
    if (!(converter_enabled && converter_idle)) begin
      nxt_idle_cnt = '0;
      nxt_settled  = 1'b0;
    end else if (idle_cnt_ff != IDLE_TARGET) begin
      nxt_idle_cnt = idle_cnt_ff + 1'b1;
    end else begin
      nxt_settled  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      idle_cnt_ff <= '0;
      settled_ff  <= 1'b0;
    end else begin
      idle_cnt_ff <= nxt_idle_cnt;
      settled_ff  <= nxt_settled;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite address and data phase
  // ----------------------------------------------------------------
  always_comb begin
    addr_phase  = hsel && hready && (htrans == AGC_HTRANS_NONSEQ || htrans == AGC_HTRANS_SEQ);
    nxt_wr_pend = addr_phase && hwrite;
    nxt_wr_addr = addr_phase ? haddr : wr_addr_ff;
    nxt_hrdata  = hrdata_ff;
    if (addr_phase && !hwrite) begin
      case (haddr)
        AGC_VOLT_GAIN_ADDR: nxt_hrdata = {{(32-DATA_W){1'b0}}, volt_gain_ff};
        AGC_TEMP_GAIN_ADDR: nxt_hrdata = {{(32-DATA_W){1'b0}}, temp_gain_ff};
        AGC_STATUS_ADDR: begin
          nxt_hrdata = '0;
          nxt_hrdata[AGC_STAT_ENABLED]  = converter_enabled;
          nxt_hrdata[AGC_STAT_IDLE]     = converter_idle;
          nxt_hrdata[AGC_STAT_SETTLED]  = settled_ff;
          nxt_hrdata[AGC_STAT_REJECTED] = rejected_ff;
        end
        AGC_VOLT_RES_ADDR: nxt_hrdata = {{(32-DATA_W){1'b0}}, volt_result};
        AGC_TEMP_RES_ADDR: nxt_hrdata = {{(32-DATA_W){1'b0}}, temp_result};
        default:           nxt_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      hrdata_ff  <= '0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff  <= nxt_hrdata;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;           // Zero wait states
  assign hresp     = AGC_HRESP_OKAY;

  // ----------------------------------------------------------------
  // Coefficient registers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_volt_gain   = volt_gain_ff;
    nxt_temp_gain   = temp_gain_ff;
    nxt_trim_loaded = 1'b1;
    nxt_rejected    = rejected_ff;
    if (!trim_loaded_ff) begin
      nxt_volt_gain = trim_volt_gain;
      nxt_temp_gain = trim_temp_gain;
    end else begin
      if (wr_pend_ff && (wr_addr_ff == AGC_VOLT_GAIN_ADDR ||
                         wr_addr_ff == AGC_TEMP_GAIN_ADDR)) begin
        if (settled_ff) begin
          nxt_rejected = 1'b0;
          if (wr_addr_ff == AGC_VOLT_GAIN_ADDR) begin
            nxt_volt_gain = hwdata[DATA_W-1:0];
          end else begin
            nxt_temp_gain = hwdata[DATA_W-1:0];
          end
        end else begin
          nxt_rejected = 1'b1;
        end
      end
      if (volt_cal_done) begin
        nxt_volt_gain = cal_gain;
      end
      if (temp_cal_done) begin
        nxt_temp_gain = cal_gain;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      volt_gain_ff   <= '0;
      temp_gain_ff   <= '0;
      trim_loaded_ff <= 1'b0;
      rejected_ff    <= 1'b0;
    end else begin
      volt_gain_ff   <= nxt_volt_gain;
      temp_gain_ff   <= nxt_temp_gain;
      trim_loaded_ff <= nxt_trim_loaded;
      rejected_ff    <= nxt_rejected;
    end
  end

  assign volt_gain = volt_gain_ff;
  assign temp_gain = temp_gain_ff;

  // ----------------------------------------------------------------
  // Result scaling
  // ----------------------------------------------------------------
  // voltage scaling
  agc_scaler #(
    .DATA_W (DATA_W)
  ) u_volt_scaler (
    .clock           (clock),
    .rst_sync_b      (rst_sync_ff),
    .sample_valid    (volt_sample_valid),
    .sample          (volt_sample),
    .gain            (volt_gain_ff),
    .scaled_ff       (volt_result),
    .scaled_valid_ff (volt_result_valid)
  );

  agc_scaler #(
    .DATA_W (DATA_W)
  ) u_temp_scaler (
    .clock           (clock),
    .rst_sync_b      (rst_sync_ff),
    .sample_valid    (temp_sample_valid),
    .sample          (temp_sample),
    .gain            (temp_gain_ff),
    .scaled_ff       (temp_result),
    .scaled_valid_ff (temp_result_valid)
  );

endmodule

//--- agc_properties.sv
`timescale 1ns/10ps
// ----
// Gain checker
// ----
module agc_properties
  import agc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        converter_enabled,
  input wire logic        converter_idle,
  input wire logic        volt_cal_done,
  input wire logic        temp_cal_done,
  input wire logic [15:0] cal_gain,
  input wire logic        volt_sample_valid,
  input wire logic [15:0] volt_sample,
  input wire logic        temp_sample_valid,
  input wire logic [15:0] temp_sample,
  input wire logic [15:0] volt_result,
  input wire logic [15:0] temp_result,
  input wire logic [15:0] volt_gain,
  input wire logic [15:0] temp_gain
);
  logic       wr_ff;
  logic [9:0] idl_ff;

  // Scaled result, saturated
  function automatic logic [15:0] scl(logic [15:0] s, logic [15:0] g);
    logic [31:0] p;
    p = s * g;
    return p[31] ? 16'hffff : p[30:15];
  endfunction

  // Voltage gain write data phase, idle run length
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff  <= 1'b0;
      idl_ff <= 10'h0;
    end else begin
      wr_ff  <= hsel && hready && htrans[1] && hwrite && haddr == AGC_VOLT_GAIN_ADDR;
      idl_ff <= (converter_enabled && converter_idle) ? idl_ff + {9'h0, ~&idl_ff} : 10'h0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Write data phase, no calibration beside it
  sequence s_wv;
    wr_ff && !volt_cal_done;
  endsequence

  volt_cal_a: assert property (volt_cal_done |=> volt_gain == $past(cal_gain))
    else $error("volt cal not loaded");
  temp_cal_a: assert property (temp_cal_done |=> temp_gain == $past(cal_gain))
    else $error("temp cal not loaded");
  volt_scale_a: assert property (volt_sample_valid |=>
    volt_result == scl($past(volt_sample), $past(volt_gain))) else $error("volt result");
  temp_scale_a: assert property (temp_sample_valid |=>
    temp_result == scl($past(temp_sample), $past(temp_gain))) else $error("temp result");
  early_reject_a: assert property (s_wv ##0 (idl_ff < 10'd460) |=> $stable(volt_gain))
    else $error("early write taken");
  write_accept_a: assert property (s_wv ##0 (idl_ff > 10'd470) |=>
    volt_gain == $past(hwdata[15:0])) else $error("write dropped");
  gain_read_a: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr == AGC_VOLT_GAIN_ADDR |=> hrdata == {16'h0, $past(volt_gain)}) else $error("read");
endmodule

bind agc_regs agc_properties agc_properties_i (.*);

//--- testbench.sv
`timescale 1ns/10ps
// ----
// Gain bench
// ----
module testbench
  import agc_pkg::*;
;
  localparam logic [31:0] GA [2] = '{AGC_VOLT_GAIN_ADDR, AGC_TEMP_GAIN_ADDR};
  logic        clock, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic        converter_enabled, converter_idle, volt_cal_done, temp_cal_done;
  logic        volt_sample_valid, temp_sample_valid, volt_result_valid, temp_result_valid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] trim_volt_gain, trim_temp_gain, cal_gain, volt_sample, temp_sample;
  logic [15:0] volt_result, temp_result, volt_gain, temp_gain;
  logic [15:0] g [2];
  int          n_mismatch, n_tests, cyc;

  assign hready = hreadyout;
  agc_regs agc_regs_i (.*);

  // Clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [15:0] scl(logic [15:0] s, logic [15:0] k);
    logic [31:0] p;
    p = s * k;
    return p[31] ? 16'hffff : p[30:15];
  endfunction

  // Expected status word, converter enabled, idle and settled
  function automatic logic [31:0] stv(logic rj);
    stv                    = '0;
    stv[AGC_STAT_ENABLED]  = 1'b1;
    stv[AGC_STAT_IDLE]     = 1'b1;
    stv[AGC_STAT_SETTLED]  = 1'b1;
    stv[AGC_STAT_REJECTED] = rj;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One single transfer, read data into r
  task automatic bus(logic [31:0] a, logic w, logic [31:0] dat);
    @(posedge clock);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, AGC_HTRANS_NONSEQ};
    do @(posedge clock); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, dat};
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic gchk();
    for (int k = 0; k < 2; k++) begin
      bus(GA[k], 1'b0, 32'h0);
      chk(r, {16'h0, g[k]});
    end
  endtask

  task automatic cal(int ch, logic [15:0] v);
    @(posedge clock);
    {cal_gain, volt_cal_done, temp_cal_done} <= {v, ch == 0, ch == 1};
    @(posedge clock);
    {volt_cal_done, temp_cal_done} <= 2'h0;
    g[ch] = v;
  endtask

  task automatic smp(logic [15:0] sv, logic [15:0] st);
    @(posedge clock);
    {volt_sample_valid, temp_sample_valid, volt_sample, temp_sample} <= {2'h3, sv, st};
    @(posedge clock);
    {volt_sample_valid, temp_sample_valid} <= 2'h0;
    @(posedge clock);
    chk({15'h0, volt_result_valid, volt_result}, {15'h0, 1'b1, scl(sv, g[0])});
    chk({15'h0, temp_result_valid, temp_result}, {15'h0, 1'b1, scl(st, g[1])});
  endtask

  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(60));
    {rst_b, hsel, hwrite, htrans, haddr, hwdata, cal_gain} = '0;
    {converter_enabled, converter_idle, volt_cal_done, temp_cal_done} = 4'h0;
    {volt_sample_valid, temp_sample_valid, volt_sample, temp_sample} = '0;
    {hsize, trim_volt_gain, trim_temp_gain} = {AGC_HSIZE_WORD, 32'($urandom)};
    {n_mismatch, n_tests, cyc} = '0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    g = '{trim_volt_gain, trim_temp_gain};
    chk({volt_gain, temp_gain}, {g[0], g[1]});
    gchk();
    // Disabled, then idle too briefly: writes dropped
    for (int k = 0; k < 2; k++) begin
      bus(GA[0], 1'b1, $urandom);
      bus(GA[1], 1'b1, $urandom);
      gchk();
      {converter_enabled, converter_idle} <= 2'h3;
    end
    repeat (AGC_IDLE_CYCLES + 20) @(posedge clock);
    // Settled, earlier writes left the rejected mark
    bus(AGC_STATUS_ADDR, 1'b0, 32'h0);
    chk(r, stv(1'b1));
    chk({31'h0, hresp}, {31'h0, AGC_HRESP_OKAY});
    for (int k = 0; k < 4; k++) begin
      g[k % 2] = (k == 0) ? 16'hffff : 16'($urandom);
      bus(GA[k % 2], 1'b1, {16'hffff, g[k % 2]});
      gchk();
    end
    // Accepted writes clear the rejected mark
    bus(AGC_STATUS_ADDR, 1'b0, 32'h0);
    chk(r, stv(1'b0));
    // Unmapped place
    bus(32'hffff0548, 1'b1, $urandom);
    bus(32'hffff0548, 1'b0, 32'h0);
    chk(r, 32'h0);
    gchk();
    // Self calibration
    for (int k = 0; k < 2; k++) begin
      cal(k, 16'($urandom));
      gchk();
    end
    // Saturation, unity, random scaling
    cal(0, 16'hffff);
    smp(16'hffff, 16'hffff);
    // Saturated result seen through the bus
    bus(AGC_VOLT_RES_ADDR, 1'b0, 32'h0);
    chk(r, 32'h0000ffff);
    cal(0, 16'h8000);
    for (int k = 0; k < 16; k++) smp(16'($urandom), 16'($urandom));
    test_done();
  end
endmodule
